// [bench/mcu_fetch_pc_stack_core_bench.sv]
// Self-checking bench of the sequencing core.
// Assumes the program memory model, the core package and its constants header.
`timescale 1ns/1ps
`default_nettype none
`include "mcu_core_defs.svh"
module mcu_fetch_pc_stack_core_bench;
   import mcu_core_pkg::*;
   localparam int DEPTH = 2;
   logic        sys_clk;
   logic        reset;
   apb_req_t    req;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] pdata;
   logic [11:0] paddr;
   logic        irq;
   logic        irq_req;
   logic        ack;
   logic [3:0]  phase;
   logic [7:0]  acc;
   logic [3:0]  stat;
   logic [31:0] rd;
   logic        err;
   logic [31:0] seed;
   logic [7:0]  a;
   logic [7:0]  b;
   logic [8:0]  e;
   logic [3:0]  prev;
   logic [3:0]  aops [11];
   int          n_mismatch;
   int          checks_done;

   mcu_fetch_pc_stack_core #(.STACK_DEPTH(DEPTH)) mcu_fetch_pc_stack_core_inst (
      .sys_clk_i(sys_clk), .reset_i(reset), .apb_req_i(req), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .pmem_data_i(pdata), .pmem_addr_o(paddr),
      .irq_i(irq), .irq_ack_o(ack), .instruction_phase_clocks_o(phase), .acc_o(acc),
      .status_o(stat));
   pmem_model pmem_model_inst (
      .sys_clk_i(sys_clk), .addr_i(paddr), .irq_req_i(irq_req), .data_o(pdata), .irq_o(irq));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [15:0] ins(input logic [3:0] op, input logic [11:0] arg);
      return {op, arg};
   endfunction : ins

   function automatic logic [15:0] alu(input logic [3:0] op, input logic [7:0] imm);
      return {4'h1, op, imm};
   endfunction : alu

   // Reference result, bit 8 is the expected carry
   function automatic logic [8:0] model(input logic [3:0] op, input logic [7:0] x, input logic [7:0] y);
      case (op)
         4'h0: return {1'b0, x} + {1'b0, y};
         4'h2: return {1'b0, x} + {1'b0, ~y} + 9'h001;
         4'h5: return {1'b0, x & y};
         4'h6: return {1'b0, x | y};
         4'h7: return {1'b0, x ^ y};
         4'h8: return {1'b0, ~x};
         4'h9: return {1'b0, x[0], x[7:1]};
         4'hB: return {1'b0, x[6:0], x[7]};
         4'hD: return {1'b0, x + 8'h01};
         default: return {1'b0, x - 8'h01};
      endcase
   endfunction : model

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   task automatic tmo(input string what);
      n_mismatch++;
      $display("CHECK FAILED %s expected done seen timeout", what);
      give_verdict();
   endtask : tmo

   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      req <= '{1'b1, 1'b0, w, ad, d};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) tmo("apb ready");
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic put(input logic [11:0] ad, input logic [15:0] w);
      pmem_model_inst.mem[ad] = w;
   endtask : put

   task automatic restart;
      for (int i = 0; i < 4096; i++) pmem_model_inst.mem[i] = 16'h0000;
      put(12'h004, alu(4'h0, 8'h05));
      put(12'h005, ins(4'h5, 12'h000));
   endtask : restart

   task automatic run;
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
   endtask : run

   task automatic wait_pc(input logic [11:0] ad);
      int n;
      n = 0;
      while (paddr !== ad && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      if (paddr !== ad) tmo("fetch address");
      repeat (12) @(posedge sys_clk);
   endtask : wait_pc

   task automatic wait_ack(input logic exp, input int lim);
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < lim; n++) begin
         @(posedge sys_clk);
         #1 if (ack === 1'b1) seen = 1'b1;
      end
      chk("interrupt acknowledge", {31'h0, exp}, {31'h0, seen});
   endtask : wait_ack

   task automatic pulse_irq;
      @(posedge sys_clk);
      irq_req <= 1'b1;
      @(posedge sys_clk);
      irq_req <= 1'b0;
   endtask : pulse_irq

   task automatic stat_chk(input logic [31:0] exp);
      apb(1'b0, `STAT_OFS, 32'h0000_0000);
      chk("status word", exp, rd & 32'h0000_10FF);
   endtask : stat_chk

   initial begin
      aops = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB, 4'hD, 4'hE, 4'h0};
      req = '0;
      irq_req = 1'b0;
      reset = 1'b1;
      seed = 32'h0001_3927;
      n_mismatch = 0;
      checks_done = 0;
      restart();
      put(12'h000, ins(4'h2, 12'h000));
      repeat (20) @(posedge sys_clk);
      chk("pc at reset", 32'h0000_0000, {20'h0, paddr});
      reset <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         prev = phase;
         @(posedge sys_clk);
         #1 chk("phase", {28'h0, prev[2:0], prev[3]}, {28'h0, phase});
      end
      apb(1'b0, `CTRL_OFS, 32'h0000_0000);
      chk("control reset", 32'h0000_0000, rd);
      apb(1'b1, `CTRL_OFS, 32'h0000_0001);
      apb(1'b0, `CTRL_OFS, 32'h0000_0000);
      chk("control readback", 32'h0000_0001, rd);
      @(posedge sys_clk);
      #1 prev = phase;
      repeat (4) @(posedge sys_clk);
      #1 chk("slow phase", {28'h0, prev[2:0], prev[3]}, {28'h0, phase});
      apb(1'b1, `CTRL_OFS, 32'h0000_0000);
      apb(1'b1, `STAT_OFS, 32'hFFFF_FFFF);
      stat_chk(32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, err});
      $display("register test done");
      for (int k = 0; k < 11; k++) begin
         seed = lfsr(seed);
         a = seed[7:0];
         b = seed[15:8];
         e = model(aops[k], a, b);
         restart();
         put(12'h000, alu(4'hF, a));
         put(12'h001, {(k == 10) ? 4'hA : 4'h1, aops[k], b});
         put(12'h002, ins(4'h2, 12'h002));
         run();
         wait_pc(12'h002);
         chk("accumulator", {24'h0, e[7:0]}, {24'h0, acc});
         if (aops[k] != 4'h9 && aops[k] != 4'hB) chk("zero flag", {31'h0, e[7:0] == 8'h00}, {31'h0, stat[2]});
         if (k < 2) chk("carry flag", {31'h0, e[8]}, {31'h0, stat[0]});
      end
      $display("alu test done");
      restart();
      put(12'h000, alu(4'hF, 8'h00));
      put(12'h001, ins(4'h6, 12'h000));
      put(12'h002, alu(4'hF, 8'h11));
      put(12'h003, ins(4'h7, 12'h000));
      put(12'h004, alu(4'h0, 8'h02));
      put(12'h005, ins(4'h3, 12'h010));
      put(12'h006, ins(4'h2, 12'h106));
      put(12'h010, alu(4'h0, 8'h40));
      put(12'h011, ins(4'h4, 12'h000));
      put(12'h106, ins(4'h2, 12'h106));
      put(12'h120, alu(4'h0, 8'h01));
      put(12'h121, ins(4'h2, 12'h121));
      run();
      wait_pc(12'h106);
      stat_chk(32'h0000_0042);
      apb(1'b1, `PC_LOW_OFS, 32'h0000_0020);
      wait_pc(12'h121);
      stat_chk(32'h0000_0043);
      $display("branch test done");
      restart();
      put(12'h000, alu(4'hF, 8'h35));
      put(12'h001, ins(4'h8, 12'h000));
      put(12'h002, ins(4'h2, 12'h002));
      put(12'h035, ins(4'h9, 12'h000));
      put(12'h036, ins(4'h2, 12'h036));
      run();
      wait_pc(12'h036);
      chk("low byte read", 32'h0000_0036, {24'h0, acc});
      apb(1'b0, `PC_LOW_OFS, 32'h0000_0000);
      chk("low byte register", 32'h0000_0036, rd & 32'hFFFF_FFFE);
      $display("low byte test done");
      restart();
      put(12'h000, ins(4'h2, 12'h010));
      put(12'h010, alu(4'hF, 8'h00));
      put(12'h011, ins(4'h2, 12'h011));
      run();
      wait_pc(12'h011);
      pulse_irq();
      wait_ack(1'b0, 40);
      stat_chk(32'h0000_1000);
      apb(1'b1, `CTRL_OFS, 32'h0000_0002);
      wait_ack(1'b1, 60);
      wait_pc(12'h011);
      stat_chk(32'h0000_0005);
      put(12'h011, ins(4'h3, 12'h020));
      put(12'h020, ins(4'h3, 12'h030));
      put(12'h021, ins(4'h2, 12'h021));
      put(12'h030, ins(4'h2, 12'h030));
      run();
      apb(1'b1, `CTRL_OFS, 32'h0000_0002);
      wait_pc(12'h030);
      pulse_irq();
      wait_ack(1'b0, 40);
      put(12'h030, ins(4'h4, 12'h000));
      wait_ack(1'b1, 60);
      wait_pc(12'h021);
      stat_chk(32'h0000_0005);
      $display("interrupt test done");
      put(12'h030, ins(4'h3, 12'h040));
      put(12'h031, alu(4'h0, 8'h02));
      put(12'h032, ins(4'h4, 12'h000));
      put(12'h040, alu(4'h0, 8'h01));
      put(12'h041, ins(4'h4, 12'h000));
      put(12'h021, alu(4'h0, 8'h04));
      put(12'h022, ins(4'h2, 12'h022));
      run();
      wait_pc(12'h022);
      stat_chk(32'h0000_0007);
      $display("overflow test done");
      give_verdict();
   end
endmodule : mcu_fetch_pc_stack_core_bench
`default_nettype wire

// [bench/pmem_model.sv]
// Program memory and interrupt source beside the sequencing core.
// Assumes the core fetches one word per instruction on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module pmem_model (
   input  wire logic        sys_clk_i,
   input  wire logic [11:0] addr_i,
   input  wire logic        irq_req_i,
   output logic [15:0]      data_o,
   output logic             irq_o
);
   logic [15:0] mem [4096];
   // Word answers within the fetch phase
   assign data_o = mem[addr_i];
   // Request line driven from the core clock
   always_ff @(posedge sys_clk_i) begin
      irq_o <= irq_req_i;
   end
endmodule : pmem_model
`default_nettype wire

// [rtl/mcu_core_defs.svh]
// Offsets, field positions, reset values and counts of the sequencing core.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
`ifndef MCU_CORE_DEFS_SVH
`define MCU_CORE_DEFS_SVH
`define CTRL_OFS        12'h000
`define PC_LOW_OFS      12'h004
`define STAT_OFS        12'h008
`define CTRL_OSC_BIT    0
`define CTRL_INTEN_BIT  1
`define PC_RESET        12'h000
`define INT_VECTOR      12'h004
`define STACK_DEPTH_DEF 8
`define SLOW_DIV        8'h04
`define FLAG_C          0
`define FLAG_AC         1
`define FLAG_Z          2
`define FLAG_OV         3
`define STAT_PEND_BIT   12
`endif

// [rtl/mcu_core_pkg.sv]
// Types of the instruction sequencing core.
// Assumes the constants header is compiled alongside.
package mcu_core_pkg;
   typedef enum logic [1:0] {
      PH_T1 = 2'b00,
      PH_T2 = 2'b01,
      PH_T3 = 2'b10,
      PH_T4 = 2'b11
   } phase_t;
   typedef enum logic [3:0] {
      OP_NOP   = 4'h0,
      OP_ALU   = 4'h1,
      OP_JUMP       = 4'h2,
      OP_CALL       = 4'h3,
      OP_RETURN     = 4'h4,
      OP_INT_RETURN = 4'h5,
      OP_SZ         = 4'h6,
      OP_SNZ        = 4'h7,
      OP_WRLOW      = 4'h8,
      OP_RDLOW      = 4'h9,
      OP_EXT   = 4'hA
   } opcode_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
endpackage : mcu_core_pkg

// [rtl/mcu_fetch_pc_stack_core.sv]
// Instruction sequencing core: phase clocks, fetch pipeline, PC, return stack, ALU.
// Assumes program memory answers on the same clock and an APB master on sys_clk_i.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mcu_core_defs.svh"
module mcu_fetch_pc_stack_core
   import mcu_core_pkg::*;
#(
   parameter int STACK_DEPTH = `STACK_DEPTH_DEF
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire apb_req_t    apb_req_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [15:0] pmem_data_i,
   output logic [11:0]      pmem_addr_o,
   input  wire logic        irq_i,
   output logic             irq_ack_o,
   output logic [3:0]       instruction_phase_clocks_o,
   output logic [7:0]       acc_o,
   output logic [3:0]       status_o
);
   localparam int SPW = $clog2(STACK_DEPTH);

   phase_t             phase;
   logic [7:0]         div_cnt;
   logic               osc_slow_sel;
   logic               int_en;
   logic [11:0]        pc;
   logic [15:0]        fetch_word;
   logic [15:0]        ir;
   logic               ir_valid;
   logic               ext_stage;
   logic [7:0]         acc;
   logic [3:0]         status;
   logic               irq_pending;
   logic               low_pend;
   logic [7:0]         low_val;
   logic [11:0]        stack_mem [STACK_DEPTH];
   logic [SPW-1:0]     sp_ptr;
   logic [SPW:0]       sp_cnt;
   logic [3:0]         phase_oh;

   // Phase timing
   wire                tick     = !osc_slow_sel || (div_cnt == 8'h00);
   wire                boundary = tick && (phase == PH_T4);
   wire                fetch_en = tick && (phase == PH_T1);

   // Decode
   wire opcode_t       opcode   = opcode_t'(ir[15:12]);
   wire [3:0]          alu_op   = ir[11:8];
   wire [7:0]          imm      = ir[7:0];
   wire [11:0]         target   = ir[11:0];
   wire                stack_full = (sp_cnt == (SPW+1)'(STACK_DEPTH));
   wire                take_int = irq_pending && int_en && !stack_full && ir_valid && !ext_stage;
   wire                run_ir   = !take_int && !low_pend && ir_valid;
   wire                is_call  = run_ir && (opcode == OP_CALL);
   wire                is_ret   = run_ir && (opcode == OP_RETURN || opcode == OP_INT_RETURN);
   wire                do_push  = boundary && (take_int || is_call);
   wire                do_pop   = boundary && is_ret;
   wire                ext_hold = run_ir && (opcode == OP_EXT) && !ext_stage;
   wire                alu_exec = run_ir && (opcode == OP_ALU || (opcode == OP_EXT && ext_stage));
   wire                skip_met = run_ir && ((opcode == OP_SZ && acc == 8'h00)
                                  || (opcode == OP_SNZ && acc != 8'h00));
   wire [SPW-1:0]      sp_prev  = (sp_ptr == '0) ? SPW'(STACK_DEPTH - 1) : sp_ptr - 1'b1;
   wire [SPW-1:0]      sp_next  = (sp_ptr == SPW'(STACK_DEPTH - 1)) ? '0 : sp_ptr + 1'b1;
   wire [11:0]         pop_val  = stack_mem[sp_prev];
   wire [11:0]         push_val = take_int ? pc - 12'h001 : pc;

   // ALU
   function automatic logic [11:0] alu_f(input logic [3:0] op, input logic [7:0] a,
                                         input logic [7:0] b, input logic cin);
      logic [8:0] s;
      logic [4:0] h;
      logic       ov;
      logic [7:0] r;
      logic [8:0] d;
      s  = 9'h000;
      h  = 5'h00;
      ov = 1'b0;
      r  = 8'h00;
      d  = {1'b0, a};
      unique case (op)
         4'h0, 4'h1: begin
            s  = {1'b0, a} + {1'b0, b} + {8'h00, op[0] & cin};
            h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, op[0] & cin};
            ov = (a[7] == b[7]) && (s[7] != a[7]);
            r  = s[7:0];
         end
         4'h2, 4'h3: begin
            s  = {1'b0, a} + {1'b0, ~b} + {8'h00, op[0] ? cin : 1'b1};
            h  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, op[0] ? cin : 1'b1};
            ov = (a[7] != b[7]) && (s[7] != a[7]);
            r  = s[7:0];
         end
         4'h4: begin
            if (a[3:0] > 4'h9) d = d + 9'h006;
            if (d[7:4] > 4'h9 || cin) d = d + 9'h060;
            s = {d[8] | cin, d[7:0]};
            r = d[7:0];
         end
         4'h5: r = a & b;
         4'h6: r = a | b;
         4'h7: r = a ^ b;
         4'h8: r = ~a;
         4'h9: r = {a[0], a[7:1]};
         4'hA: begin
            r = {cin, a[7:1]};
            s[8] = a[0];
         end
         4'hB: r = {a[6:0], a[7]};
         4'hC: begin
            r = {a[6:0], cin};
            s[8] = a[7];
         end
         4'hD: r = a + 8'h01;
         4'hE: r = a - 8'h01;
         4'hF: r = b;
      endcase
      alu_f = {s[8], h[4], ov, (r == 8'h00), r};
   endfunction : alu_f

   wire [11:0] alu_res = alu_f(alu_op, acc, imm, status[`FLAG_C]);
   wire        carry_op = (alu_op <= 4'h4) || (alu_op == 4'hA) || (alu_op == 4'hC);
   wire        arith_op = (alu_op <= 4'h3);

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_cnt <= 8'h00;
      end else if (!osc_slow_sel || div_cnt == `SLOW_DIV - 8'h01) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase <= PH_T1;
      end else if (tick) begin
         phase <= phase_t'(phase + 2'b01);
      end
   end

   // Phase clocks one-hot
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ph
         always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
               phase_oh[gi] <= (gi == 0);
            end else if (tick) begin
               phase_oh[gi] <= (phase_t'(phase + 2'b01) == phase_t'(gi));
            end
         end
      end
   endgenerate
   assign instruction_phase_clocks_o = phase_oh;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fetch_word <= 16'h0000;
      end else if (fetch_en) begin
         fetch_word <= pmem_data_i;
      end
   end

   // Program counter and pipeline
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pc        <= `PC_RESET;
         ir        <= 16'h0000;
         ir_valid  <= 1'b0;
         ext_stage <= 1'b0;
      end else if (boundary) begin
         if (take_int || low_pend || (run_ir && (opcode == OP_JUMP || opcode == OP_CALL
             || opcode == OP_RETURN || opcode == OP_INT_RETURN || opcode == OP_WRLOW))) begin
            pc       <= take_int ? `INT_VECTOR :
                        low_pend ? {pc[11:8], low_val} :
                        (opcode == OP_JUMP || opcode == OP_CALL) ? target :
                        (opcode == OP_WRLOW) ? {pc[11:8], acc} : pop_val;
            ir_valid <= 1'b0;
         end else if (ext_hold) begin
            ext_stage <= 1'b1;
         end else if (skip_met) begin
            pc       <= pc + 12'h001;
            ir_valid <= 1'b0;
         end else begin
            pc        <= pc + 12'h001;
            ir        <= fetch_word;
            ir_valid  <= 1'b1;
            ext_stage <= 1'b0;
         end
      end
   end
   assign pmem_addr_o = pc;

   always_ff @(posedge sys_clk_i) begin
      if (do_push) begin
         stack_mem[sp_ptr] <= push_val;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sp_ptr <= '0;
         sp_cnt <= '0;
      end else if (do_push) begin
         sp_ptr <= sp_next;
         sp_cnt <= stack_full ? sp_cnt : sp_cnt + 1'b1;
      end else if (do_pop) begin
         sp_ptr <= sp_prev;
         sp_cnt <= (sp_cnt == '0) ? sp_cnt : sp_cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         acc    <= 8'h00;
         status <= 4'h0;
      end else if (boundary && alu_exec) begin
         acc                 <= alu_res[7:0];
         status[`FLAG_Z]     <= alu_res[8];
         status[`FLAG_C]     <= carry_op ? alu_res[11] : status[`FLAG_C];
         status[`FLAG_AC]    <= arith_op ? alu_res[10] : status[`FLAG_AC];
         status[`FLAG_OV]    <= arith_op ? alu_res[9] : status[`FLAG_OV];
      end else if (boundary && run_ir && opcode == OP_RDLOW) begin
         acc <= pc[7:0];
      end
   end
   assign acc_o    = acc;
   assign status_o = status;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_pending <= 1'b0;
         irq_ack_o   <= 1'b0;
      end else begin
         irq_pending <= irq_i || (irq_pending && !(boundary && take_int));
         irq_ack_o   <= boundary && take_int;
      end
   end

   // APB slave, one wait state
   wire        apb_acc  = apb_req_i.psel && apb_req_i.penable;
   wire        apb_done = apb_acc && pready_o;
   wire        sel_ctrl = apb_req_i.paddr == `CTRL_OFS;
   wire        sel_low  = apb_req_i.paddr == `PC_LOW_OFS;
   wire        sel_stat = apb_req_i.paddr == `STAT_OFS;
   wire        mapped   = sel_ctrl || sel_low || sel_stat;
   wire [31:0] rd_mux   = sel_ctrl ? {30'h0, int_en, osc_slow_sel} :
                          sel_low  ? {24'h0, pc[7:0]} :
                          sel_stat ? {19'h0, irq_pending, status, acc} : 32'h0;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0;
      end else begin
         pready_o  <= apb_acc && !pready_o;
         pslverr_o <= apb_acc && !pready_o && !mapped;
         prdata_o  <= (apb_acc && !pready_o && !apb_req_i.pwrite) ? rd_mux : 32'h0;
      end
   end

   // Control bits
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         osc_slow_sel <= 1'b0;
         int_en       <= 1'b0;
      end else begin
         if (apb_done && apb_req_i.pwrite && sel_ctrl) begin
            osc_slow_sel <= apb_req_i.pwdata[`CTRL_OSC_BIT];
         end
         if (boundary && take_int) begin
            int_en <= 1'b0;
         end else if (boundary && run_ir && opcode == OP_INT_RETURN) begin
            int_en <= 1'b1;
         end else if (apb_done && apb_req_i.pwrite && sel_ctrl) begin
            int_en <= apb_req_i.pwdata[`CTRL_INTEN_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_pend <= 1'b0;
         low_val  <= 8'h00;
      end else if (apb_done && apb_req_i.pwrite && sel_low) begin
         low_pend <= 1'b1;
         low_val  <= apb_req_i.pwdata[7:0];
      end else if (boundary) begin
         low_pend <= 1'b0;
      end
   end

   // Checks
   phase_onehot_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $onehot(instruction_phase_clocks_o)) else $error("phase clocks not one-hot");
   pc_advance_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      boundary && run_ir && opcode == OP_NOP |=> pc == $past(pc) + 12'h001)
      else $error("pc did not advance by one");
   jump_target_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      boundary && run_ir && opcode == OP_JUMP |=> pc == $past(target) && !ir_valid)
      else $error("jump target not loaded");
   skip_dummy_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      boundary && skip_met && !ext_hold |=> !ir_valid) else $error("skip kept prefetch");
   low_page_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      boundary && run_ir && opcode == OP_WRLOW |=> pc == {$past(pc[11:8]), $past(acc)})
      else $error("low byte jump left page");
   call_push_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      do_push && !stack_full |=> sp_cnt == $past(sp_cnt) + 1'b1) else $error("push lost");
   int_defer_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      stack_full |-> !take_int) else $error("interrupt taken on full stack");
   ret_restore_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      do_pop && !take_int |=> pc == $past(pop_val)) else $error("return address wrong");
   apb_ready_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      apb_acc && !pready_o |=> pready_o ##1 !pready_o) else $error("apb ready timing");
   ext_second_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      boundary && ext_hold |=> ext_stage && pc == $past(pc))
      else $error("extended instruction did not hold");
   int_vector_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      boundary && take_int |=> irq_ack_o && pc == `INT_VECTOR)
      else $error("interrupt vector not loaded");
   overflow_wrap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      do_push && stack_full |=> stack_full && sp_ptr == $past(sp_next))
      else $error("overflow push not wrapped");
   low_read_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      boundary && run_ir && opcode == OP_RDLOW |=> acc == $past(pc[7:0]))
      else $error("low byte read wrong");
endmodule : mcu_fetch_pc_stack_core
`default_nettype wire
